// file: src/bpf_framer.sv
`timescale 1ns/10ps
// Contract
// R1 - words are 24 bits; bit 1 is odd parity or extra bus label bit
// R2 - bus label is 3 bits with parity, 4 bits without
// R3 - every word carries a 4-bit content label after the bus label
// R4 - idle slots get fill words with info field aaaa
// R5 - after overflow, one extra marker word with content 0000 precedes data
// R6 - marker info field holds diagnostic content of our choosing
// R7 - with crc enabled, last frame word is the crc word
// R8 - check sequence uses x16 + x15 + x2 + 1
// R9 - no bit of the crc word enters the check sequence
// R10 - check covers all preceding frame bits msb first, cleared each frame
// R11 - crc content label avoids the bus data codes 1000 to 1111
// R12 - time words put their 16-bit value in the info field in order
// R13 - words go out bit 1 first at a constant bit rate
// R14 - bus word order is kept
// R15 - frame length fixed, above 128 and below 512 words with sync
// R16 - every frame starts with sync word faf320
// R17 - with frame time, sync is followed by high, low, micro time words
// R18 - without frame time data follows sync; without crc frame ends on data
// R19 - fill words may be omitted for buffered recorders
// R20 - track streams are randomized nrz-level or bi-phase-level coded
// R21 - one stream per track, each delayed 24/track_count bits from the last
// R22 - at most four tracks per bus
// R23 - all tracks share frame length, each with its own sync word
// R24 - with crc, every frame of every track gets a crc word
// R25 - four tracks with time: high, low, micro on tracks 1-3, data on 4
// R26 - words are dealt round-robin across tracks in track order
// R27 - word priority: sync, time, marker or data, fill; crc in last slot
module bpf_framer
    import bpf_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire bpf_word_t src_word,
    input wire logic src_valid,
    output logic src_ready,
    input wire logic ovf_event,
    input wire logic [3:0] ovf_bus,
    input wire bpf_time_t time_src,
    output logic [MAX_TRACKS-1:0] trk_nrz,
    output logic [MAX_TRACKS-1:0] trk_line,
    output logic [MAX_TRACKS-1:0] trk_word_valid,
    output logic bit_tick
);

    bpf_ctrl_t ctrl;
    bpf_label_t lbl;
    logic [8:0] frame_len;
    logic [15:0] half_div;
    logic [15:0] div_cnt;
    logic phase;
    logic half_stb;
    logic bit_stb;
    logic [4:0] bit_cnt;
    logic [4:0] next_bit_cnt;
    logic [4:0] step;
    logic ld_hit;
    logic [1:0] ld_trk;
    logic [8:0] ld_slot;
    logic [10:0] gidx;
    bpf_kind_t kind;
    logic [23:0] next_word;
    logic [23:0] trk_sr [MAX_TRACKS];
    logic [8:0] slot [MAX_TRACKS];
    logic [15:0] crc [MAX_TRACKS];
    logic [14:0] scr [MAX_TRACKS];
    logic [MAX_TRACKS-1:0] nbit;
    logic [MAX_TRACKS-1:0] sbit;
    bpf_time_t time_q;
    logic mark_pend;
    logic [3:0] mark_bus;
    logic [15:0] ovf_cnt;
    logic aw_hold;
    logic w_hold;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // bit-serial crc over one word, msb first
    function automatic logic [15:0] crc_word(input logic [15:0] c_in, input logic [23:0] w);
        logic [15:0] c;
        c = c_in;
        for (int i = WORD_BITS - 1; i >= 0; i--) begin
            if (c[15] ^ w[i]) begin
                c = {c[14:0], 1'b0} ^ CRC_POLY; // R8
            end else begin
                c = {c[14:0], 1'b0};
            end
        end
        return c;
    endfunction

    // build a word; bit 1 becomes odd parity or stays label msb
    function automatic logic [23:0] pack_word(input bpf_word_t w, input logic par);
        logic [23:0] v;
        v = w;
        if (par) begin
            v[23] = ~^v[22:0]; // R1 R2
        end
        return v;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bit timing

    // half-bit divider, a bit ends every second half
    assign half_stb = ctrl.enable && (div_cnt == half_div);
    assign bit_stb = half_stb && phase; // R13
    assign next_bit_cnt = (bit_cnt == 5'(WORD_BITS - 1)) ? 5'h00 : bit_cnt + 5'h01;

    always_ff @(posedge aclk) begin
        if (!aresetn || !ctrl.enable) begin
            div_cnt <= 16'h0000;
            phase <= 1'b0;
            bit_cnt <= BIT_CNT_RST;
        end else begin
            div_cnt <= half_stb ? 16'h0000 : div_cnt + 16'h0001;
            if (half_stb) begin
                phase <= ~phase;
            end
            if (bit_stb) begin
                bit_cnt <= next_bit_cnt;
            end
        end
    end

    // first cycle of each new bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bit_tick <= 1'b0;
        end else begin
            bit_tick <= bit_stb;
        end
    end

    // stagger between tracks, 24 / track_count bits
    always_comb begin
        case (ctrl.tk_m1)
            2'd0: step = 5'd24;
            2'd1: step = 5'd12;
            2'd2: step = 5'd8;
            default: step = 5'd6;
        endcase
    end

    // which track loads a fresh word at this bit edge
    always_comb begin
        ld_hit = 1'b0;
        ld_trk = 2'd0;
        for (int t = 0; t < MAX_TRACKS; t++) begin
            if (bit_stb && t <= int'(ctrl.tk_m1) && next_bit_cnt == 5'(t * int'(step))) begin
                ld_hit = 1'b1; // R21 R22
                ld_trk = 2'(t);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // word selection

    assign ld_slot = slot[ld_trk];
    // position in the round-robin sequence of words after sync
    assign gidx = 11'((int'(ld_slot) - 1) * (int'(ctrl.tk_m1) + 1) + int'(ld_trk)); // R26 R25

    // priority chain for the word entering the loading track
    always_comb begin
        if (ld_slot == 9'h000) begin
            kind = K_SYNC; // R16 R23
        end else if (ctrl.crc_en && ld_slot == frame_len - 9'h001) begin
            kind = K_CRC; // R7 R24 R27
        end else if (ctrl.time_en && gidx == 11'h000) begin
            kind = K_HI; // R17 R25
        end else if (ctrl.time_en && gidx == 11'h001) begin
            kind = K_LO;
        end else if (ctrl.time_en && gidx == 11'h002) begin
            kind = K_US;
        end else if (mark_pend) begin
            kind = K_MARK; // R5
        end else if (src_valid) begin
            kind = K_DATA; // R18
        end else begin
            kind = K_FILL; // R4
        end
    end

    // word contents per kind
    always_comb begin
        case (kind)
            K_SYNC: next_word = SYNC_WORD; // R16
            K_HI: next_word = pack_word({lbl.bus_lbl, lbl.hi_lbl, time_q.hi}, ctrl.parity); // R12
            K_LO: next_word = pack_word({lbl.bus_lbl, lbl.lo_lbl, time_q.lo}, ctrl.parity);
            K_US: next_word = pack_word({lbl.bus_lbl, lbl.us_lbl, time_q.us}, ctrl.parity);
            K_MARK: next_word = pack_word({mark_bus, OVF_CONTENT, ovf_cnt}, ctrl.parity); // R6
            K_DATA: next_word = pack_word(src_word, ctrl.parity); // R3
            K_FILL: next_word = pack_word({lbl.bus_lbl, lbl.fill_lbl, FILL_INFO}, ctrl.parity);
            default: next_word = pack_word({lbl.bus_lbl, lbl.crc_lbl, crc[ld_trk]}, ctrl.parity);
        endcase
    end

    // data leaves the source only into its own slot, in arrival order
    assign src_ready = ld_hit && kind == K_DATA; // R14

    ////////////////////////////////////////////////////////////////////////////
    // track shift registers, slot counters and check sequences

    always_ff @(posedge aclk) begin
        if (!aresetn || !ctrl.enable) begin
            for (int t = 0; t < MAX_TRACKS; t++) begin
                trk_sr[t] <= 24'h000000;
                slot[t] <= 9'h000;
                crc[t] <= CRC_INIT;
            end
            trk_word_valid <= '0;
        end else if (bit_stb) begin
            for (int t = 0; t < MAX_TRACKS; t++) begin
                if (ld_hit && ld_trk == 2'(t)) begin
                    trk_sr[t] <= next_word;
                    slot[t] <= (slot[t] == frame_len - 9'h001) ? 9'h000 : slot[t] + 9'h001; // R15
                    trk_word_valid[t] <= !(ctrl.no_fill && kind == K_FILL); // R19
                    if (kind == K_SYNC) begin
                        crc[t] <= crc_word(CRC_INIT, next_word); // R10
                    end else if (kind != K_CRC) begin
                        crc[t] <= crc_word(crc[t], next_word); // R9
                    end
                end else begin
                    trk_sr[t] <= {trk_sr[t][22:0], 1'b0}; // R13
                end
            end
        end
    end

    always_comb begin
        for (int t = 0; t < MAX_TRACKS; t++) begin
            trk_nrz[t] = trk_sr[t][23];
            nbit[t] = (ld_hit && ld_trk == 2'(t)) ? next_word[23] : trk_sr[t][22];
            sbit[t] = nbit[t] ^ scr[t][14] ^ scr[t][13];
        end
    end

    // line coding: scrambled nrz-l, or bi-phase-l inverting at mid-bit
    always_ff @(posedge aclk) begin
        if (!aresetn || !ctrl.enable) begin
            for (int t = 0; t < MAX_TRACKS; t++) begin
                scr[t] <= SCR_RST;
            end
            trk_line <= '0;
        end else begin
            for (int t = 0; t < MAX_TRACKS; t++) begin
                if (bit_stb) begin
                    scr[t] <= {scr[t][13:0], sbit[t]};
                    trk_line[t] <= ctrl.biphase ? nbit[t] : sbit[t]; // R20
                end else if (half_stb && ctrl.biphase && t <= int'(ctrl.tk_m1)) begin
                    trk_line[t] <= ~trk_line[t]; // R20
                end
            end
        end
    end

    // time latched with the first track's sync so all three words agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            time_q <= '0;
        end else if (ld_hit && ld_trk == 2'd0 && kind == K_SYNC) begin
            time_q <= time_src;
        end
    end

    // overflow marker pending; a new event wins over the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mark_pend <= 1'b0;
            mark_bus <= 4'h0;
            ovf_cnt <= 16'h0000;
        end else if (ovf_event) begin
            mark_pend <= 1'b1; // R5
            mark_bus <= ovf_bus;
            ovf_cnt <= ovf_cnt + 16'h0001;
        end else if (ld_hit && kind == K_MARK) begin
            mark_pend <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave

    assign s_axi_awready = !aw_hold && !s_axi_bvalid;
    assign s_axi_wready = !w_hold && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go = aw_hold && w_hold && !s_axi_bvalid;

    // address and data accepted in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr[7:0] == CTRL_OFS || aw_addr[7:0] == FRAME_OFS ||
                    aw_addr[7:0] == DIV_OFS || aw_addr[7:0] == LABEL_OFS ||
                    aw_addr[7:0] == STAT_OFS) begin
                    s_axi_bresp <= RESP_OKAY;
                end else begin
                    s_axi_bresp <= RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // register writes; frame length is clamped into range
    always_ff @(posedge aclk) begin
        logic [31:0] m;
        if (!aresetn) begin
            ctrl <= CTRL_RST;
            frame_len <= FRAME_RST;
            half_div <= DIV_RST;
            lbl <= LABEL_RST; // R11
        end else if (wr_go) begin
            if (aw_addr[7:0] == CTRL_OFS) begin
                m = merge({24'h000000, ctrl}, w_data, w_strb);
                ctrl <= m[7:0];
            end else if (aw_addr[7:0] == FRAME_OFS) begin
                m = merge({23'h000000, frame_len}, w_data, w_strb);
                frame_len <= (m[8:0] < FRAME_MIN) ? FRAME_MIN : m[8:0]; // R15
            end else if (aw_addr[7:0] == DIV_OFS) begin
                m = merge({16'h0000, half_div}, w_data, w_strb);
                half_div <= m[15:0];
            end else if (aw_addr[7:0] == LABEL_OFS) begin
                m = merge({8'h00, lbl}, w_data, w_strb);
                lbl <= m[23:0];
            end
        end
    end

    // read channel, answer one cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            if (s_axi_araddr[7:0] == CTRL_OFS) begin
                s_axi_rdata <= {24'h000000, ctrl};
            end else if (s_axi_araddr[7:0] == FRAME_OFS) begin
                s_axi_rdata <= {23'h000000, frame_len};
            end else if (s_axi_araddr[7:0] == DIV_OFS) begin
                s_axi_rdata <= {16'h0000, half_div};
            end else if (s_axi_araddr[7:0] == LABEL_OFS) begin
                s_axi_rdata <= {8'h00, lbl};
            end else if (s_axi_araddr[7:0] == STAT_OFS) begin
                s_axi_rdata <= {ovf_cnt, 14'h0000, mark_pend, ctrl.enable};
            end else begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic ld_q;
    logic [1:0] ld_trk_q;
    bpf_kind_t kind_q;
    logic [15:0] info_q;

    always_ff @(posedge aclk) begin
        ld_q <= ld_hit;
        ld_trk_q <= ld_trk;
        kind_q <= kind;
        info_q <= src_word.info;
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sync_word_a: assert property (ld_hit && ld_slot == 9'h000 |=> trk_sr[ld_trk_q] == 24'hfaf320) // R16
        else $error("frame did not open with sync");
    fill_info_a: assert property (ld_q && kind_q == K_FILL |-> trk_sr[ld_trk_q][15:0] == 16'haaaa) // R4
        else $error("fill word pattern wrong");
    marker_lbl_a: assert property (mark_pend && !ovf_event && ld_hit && ld_slot > 9'h003 // R5
        && ld_slot < frame_len - 9'h001
        |=> trk_sr[ld_trk_q][19:16] == OVF_CONTENT && !mark_pend)
        else $error("overflow marker not first after overflow");
    crc_slot_a: assert property (ctrl.crc_en && ld_hit && ld_slot == frame_len - 9'h001
        |=> kind_q == K_CRC && trk_sr[ld_trk_q][15:0] == $past(crc[ld_trk])) // R7
        else $error("crc word missing from last slot");
    odd_parity_a: assert property (ctrl.parity && ld_q && kind_q != K_SYNC |-> ^trk_sr[ld_trk_q]) // R1
        else $error("word parity not odd");
    msb_shift_a: assert property (bit_stb && !(ld_hit && ld_trk == 2'd0)
        |=> trk_sr[0] == {$past(trk_sr[0][22:0]), 1'b0}) // R13
        else $error("track shifted out of order");
    stagger_a: assert property (ld_hit |-> int'(next_bit_cnt) * (int'(ctrl.tk_m1) + 1) // R21
        == int'(ld_trk) * WORD_BITS)
        else $error("track load off its stagger");
    data_order_a: assert property (src_valid && src_ready |=> trk_sr[ld_trk_q][15:0] == info_q) // R14
        else $error("source word not placed in slot");
    time_first_a: assert property (ctrl.time_en && ld_hit && ld_slot == 9'h001 && ld_trk == 2'd0
        && frame_len > 9'h004 |=> kind_q == K_HI) // R17
        else $error("high time not after sync");
    frame_len_a: assert property (frame_len > 9'h080 && slot[0] < frame_len) // R15
        else $error("frame length out of range");
    biphase_mid_a: assert property (ctrl.biphase && half_stb && !phase
        |=> trk_line[0] != $past(trk_line[0])) // R20
        else $error("bi-phase missed mid-bit transition");

    crc_sent_c: cover property (ld_q && kind_q == K_CRC);
    marker_sent_c: cover property (ld_q && kind_q == K_MARK);
    four_track_c: cover property (ld_hit && ld_trk == 2'd3);
    fill_sent_c: cover property (ld_q && kind_q == K_FILL);

endmodule

// file: src/bpf_pkg.sv
package bpf_pkg;
    // fixed word patterns
    localparam logic [23:0] SYNC_WORD = 24'hfaf320;
    localparam logic [15:0] FILL_INFO = 16'haaaa;
    localparam logic [3:0] OVF_CONTENT = 4'h0;
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CRC_INIT = 16'h0000;
    localparam int WORD_BITS = 24;
    localparam int MAX_TRACKS = 4;
    localparam logic [8:0] FRAME_MIN = 9'h081;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] FRAME_OFS = 8'h04;
    localparam logic [7:0] DIV_OFS = 8'h08;
    localparam logic [7:0] LABEL_OFS = 8'h0c;
    localparam logic [7:0] STAT_OFS = 8'h10;
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [8:0] FRAME_RST = 9'h100;
    localparam logic [15:0] DIV_RST = 16'h0007;
    localparam logic [23:0] LABEL_RST = 24'h321560;
    localparam logic [4:0] BIT_CNT_RST = 5'h17;
    localparam logic [14:0] SCR_RST = 15'h0000;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // control register, bit 0 upward: enable, time, crc, parity, biphase, no_fill, tk-1
    typedef struct packed {
        logic [1:0] tk_m1;
        logic no_fill;
        logic biphase;
        logic parity;
        logic crc_en;
        logic time_en;
        logic enable;
    } bpf_ctrl_t;

    // label register, bits 3:0 bus label upward
    typedef struct packed {
        logic [3:0] us_lbl;
        logic [3:0] lo_lbl;
        logic [3:0] hi_lbl;
        logic [3:0] fill_lbl;
        logic [3:0] crc_lbl;
        logic [3:0] bus_lbl;
    } bpf_label_t;

    // one formatted word, bit 1 at the top
    typedef struct packed {
        logic [3:0] bus_lbl;
        logic [3:0] content;
        logic [15:0] info;
    } bpf_word_t;

    typedef struct packed {
        logic [15:0] hi;
        logic [15:0] lo;
        logic [15:0] us;
    } bpf_time_t;

    typedef enum logic [2:0] {
        K_SYNC = 3'b000,
        K_HI = 3'b001,
        K_LO = 3'b010,
        K_US = 3'b011,
        K_MARK = 3'b100,
        K_DATA = 3'b101,
        K_FILL = 3'b110,
        K_CRC = 3'b111
    } bpf_kind_t;
endpackage

// file: testbench/bpf_rx_model.sv
`timescale 1ns/10ps
// recorder input: collects track 0 bits into 24-bit words, msb first
module bpf_rx_model (
    input wire logic aclk,
    input wire logic clear,
    input wire logic bit_tick,
    input wire logic bit_in,
    output int word_cnt
);
    logic [23:0] words [0:255];
    logic [23:0] sh;
    int nbit;
    ////////////////////////////////////////////////////////////////
    // shift on every new bit, store the first 256 full words
    always @(posedge aclk) begin
        if (clear) begin
            nbit = 0;
            word_cnt = 0;
        end else if (bit_tick) begin
            sh = {sh[22:0], bit_in};
            nbit++;
            if (nbit == 24) begin
                if (word_cnt < 256) words[word_cnt] = sh;
                word_cnt++;
                nbit = 0;
            end
        end
    end
endmodule

// file: testbench/tb_top.sv
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
    import bpf_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, src_valid, src_ready, ovf_event, bit_tick;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb, ovf_bus, trk_nrz, trk_line, twv;
    logic [1:0] bresp, rresp, rs;
    bpf_word_t src_word;
    bpf_time_t time_src;
    logic [15:0] crc;
    int failures, check_count, wc;
    bpf_framer u_bpf_framer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .src_word(src_word), .src_valid(src_valid),
        .src_ready(src_ready), .ovf_event(ovf_event), .ovf_bus(ovf_bus), .time_src(time_src),
        .trk_nrz(trk_nrz), .trk_line(trk_line), .trk_word_valid(twv), .bit_tick(bit_tick));
    bpf_rx_model u_bpf_rx_model (.aclk(aclk), .clear(!aresetn), .bit_tick(bit_tick),
        .bit_in(trk_nrz[0]), .word_cnt(wc));
    ////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    // handshakes sampled mid-cycle, released just after the taking edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        forever begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            rs = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) begin
                bready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic axi_rd(input logic [7:0] a);
        logic ta, tr;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        forever begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid;
            rd = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tr) begin
                rready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic send(input bpf_word_t w);
        @(posedge aclk);
        src_word <= w;
        src_valid <= 1'b1;
        forever begin
            @(negedge aclk);
            if (src_ready) break;
        end
        @(posedge aclk);
        src_valid <= 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #200us;
        failures++;
        tally_and_finish();
    end
    ////////////////////////////////////////////////////////////////
    // main sequence: registers, then one framed crc run on one track
    initial begin
        aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
        rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hf;
        src_word = 24'h0; src_valid = 1'b0; ovf_event = 1'b0; ovf_bus = 4'h0;
        time_src = {16'h1111, 16'h2222, 16'h3333};
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(CTRL_OFS); `CHK(rd, 32'h0)
        axi_rd(FRAME_OFS); `CHK(rd, 32'h100)
        axi_rd(LABEL_OFS); `CHK(rd, 32'h321560)
        axi_rd(8'h20); `CHK({rs, rd}, {2'h2, 32'h0})
        axi_wr(FRAME_OFS, 32'h10); `CHK(rs, 2'h0)
        axi_rd(FRAME_OFS); `CHK(rd, 32'h81)
        axi_wr(DIV_OFS, 32'h0);
        axi_wr(CTRL_OFS, 32'h7);
        send(24'h1b1234);
        send(24'h1c5678);
        @(posedge aclk);
        ovf_bus <= 4'h2;
        ovf_event <= 1'b1;
        @(posedge aclk);
        ovf_event <= 1'b0;
        send(24'h1d9abc);
        for (int i = 0; i < 20000 && wc < 130; i++) @(posedge aclk);
        `CHK(u_bpf_rx_model.words[0], 24'hfaf320)
        `CHK(u_bpf_rx_model.words[1], 24'h011111)
        `CHK(u_bpf_rx_model.words[2], 24'h022222)
        `CHK(u_bpf_rx_model.words[3], 24'h033333)
        `CHK(u_bpf_rx_model.words[4], 24'h1b1234)
        `CHK(u_bpf_rx_model.words[5], 24'h1c5678)
        `CHK(u_bpf_rx_model.words[6][23:16], 8'h20)
        `CHK(u_bpf_rx_model.words[7], 24'h1d9abc)
        for (int i = 8; i < 128; i++) `CHK(u_bpf_rx_model.words[i], 24'h05aaaa)
        // reference check sequence over all preceding frame bits
        crc = 16'h0;
        for (int i = 0; i < 128; i++) begin
            for (int b = 23; b >= 0; b--) begin
                if (crc[15] ^ u_bpf_rx_model.words[i][b]) crc = {crc[14:0], 1'b0} ^ 16'h8005;
                else crc = {crc[14:0], 1'b0};
            end
        end
        `CHK(u_bpf_rx_model.words[128], {8'h06, crc})
        `CHK(u_bpf_rx_model.words[129], 24'hfaf320)
        `CHK(trk_nrz[3:1], 3'h0)
        axi_rd(STAT_OFS); `CHK(rd, 32'h10001)
        // mid-run reset, then four tracks with time, crc, parity, bi-phase, no fill
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(DIV_OFS); `CHK(rd, 32'h7)
        axi_wr(FRAME_OFS, 32'h81);
        axi_wr(DIV_OFS, 32'h0);
        axi_wr(CTRL_OFS, 32'hff);
        for (int i = 0; i < 2000 && wc < 3; i++) @(posedge aclk);
        @(negedge aclk);
        `CHK(twv, 4'h0)
        `CHK(u_bpf_rx_model.words[0], 24'hfaf320)
        `CHK(u_bpf_rx_model.words[1], 24'h011111)
        `CHK(u_bpf_rx_model.words[2], 24'h85aaaa)
        // first half of each bi-phase bit carries the bit itself
        for (int i = 0; i < 8; i++) begin
            @(negedge aclk);
            while (!bit_tick) @(negedge aclk);
            `CHK(trk_line[0], trk_nrz[0])
        end
        tally_and_finish();
    end
endmodule
